// ---- core/albx_pkg.sv ----
// Purpose: shared constants and types of the add/logic/branch execute slice
// Assumes: 16-bit instruction words, 32-bit registers
// Notes: register offsets are for the interrupt registers only
package albx_pkg;
  // ==========================================================
  // opcodes
  localparam logic [5:0] OP_SIGNED_ADD = 6'h0B;
  localparam logic [5:0] OP_SIGNED_ADD_IMM = 6'h1B;
  localparam logic [5:0] OP_AND = 6'h15;
  localparam logic [5:0] OP_CLEAR_BITS = 6'h0D;
  localparam logic [5:0] OP_CLEAR_BITS_IMM = 6'h1D;
  localparam logic [7:0] OP_JUMP_IF_CARRY = 8'hF4;
  localparam logic [7:0] OP_JUMP_IF_ZERO = 8'hF2;
  localparam logic [7:0] OP_JUMP_IF_NONNEG = 8'hF9;
  localparam logic [7:0] OP_JUMP_IF_POSITIVE = 8'hFB;
  localparam logic [7:0] OP_JUMP_IF_NO_CARRY = 8'hF5;
  // ==========================================================
  // state word bit positions and status register code
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_M = 4;
  localparam logic [3:0] STATE_WORD_CODE = 4'h1;
  localparam logic [31:0] STATE_WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [31:0] INSN_BYTES = 32'h0000_0002;
  // ==========================================================
  // interrupt registers
  localparam logic [3:0] REG_IRQ_STATUS = 4'h0;
  localparam logic [3:0] REG_IRQ_CLEAR = 4'h4;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h8;
  localparam int IRQ_RANGE = 0;
  localparam int IRQ_JUMP = 1;
  localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;

  typedef struct packed {
    logic bank;
    logic [3:0] code;
  } albx_reg_sel_s;

  typedef struct packed {
    logic we;
    albx_reg_sel_s sel;
    logic [31:0] data;
  } albx_reg_wr_s;
endpackage

// ---- core/albx_exec.sv ----
// Purpose: decode and execute one instruction word per valid strobe
// Assumes: register file reads are combinational on the select ports
// Notes: results, flags, pc and trap are committed on the same edge
//
// Overview of operation
// - s and d bits pick global or local bank
// - opcode 0010 11 signed add with flags
// - signed overflow raises range error trap
// - state word as source signed_add_trap carry
// - immediate selector is bit 8 and bits 3..0
// - selector zero signed_add_trap carry rounding to even
// - opcode 0101 01 and, zero flag only
// - opcode 0011 01 and with inverted source
// - immediate and with inverted immediate
// - branch offset sign extended, low field, zero
// - taken branch loads pc, clears cache mode
// - untaken branch changes nothing, pc advances
// - 1111 0100 jumps when carry set
// - 1111 0010 jumps when zero set
// - 1111 1001 jumps when sign clear
// - 1111 1011 jumps when sign and zero clear
// - 1111 0101 jumps when carry clear
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module albx_exec
  import albx_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // fetch stage
  input wire logic insn_valid_i,
  input wire logic [15:0] insn_i,
  // register file
  output albx_reg_sel_s src_sel_o,
  output albx_reg_sel_s dst_sel_o,
  input wire logic [31:0] src_data_i,
  input wire logic [31:0] dst_data_i,
  output albx_reg_wr_s wr_o,
  // immediate decode table
  output logic [4:0] imm_sel_o,
  input wire logic [31:0] imm_val_i,
  // core state
  output logic [31:0] pc_o,
  output logic [31:0] state_word_o,
  output logic range_trap_o,
  output logic illegal_o,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);
  // ==========================================================
  // field decode
  logic [5:0] op6;
  logic [7:0] op8;
  logic is_add, is_addi, is_and, is_clear_bits_op, is_clear_bits_imm_op, is_br, br_cond;
  logic [31:0] rel;
  assign op6 = {insn_i[15:12], insn_i[11:10]};
  assign op8 = insn_i[15:8];
  assign src_sel_o = '{bank: insn_i[8], code: insn_i[3:0]};
  assign dst_sel_o = '{bank: insn_i[9], code: insn_i[7:4]};
  assign imm_sel_o = {insn_i[8], insn_i[3:0]};
  assign rel = {{25{insn_i[0]}}, insn_i[6:1], 1'b0};

  logic c_q, z_q, n_q, v_q, m_q;
  logic [31:0] pc_q;
  logic c_f, z_f, n_f;
  assign c_f = c_q;
  assign z_f = z_q;
  assign n_f = n_q;

  always_comb begin
    is_add = 1'b0;
    is_addi = 1'b0;
    is_and = 1'b0;
    is_clear_bits_op = 1'b0;
    is_clear_bits_imm_op = 1'b0;
    is_br = 1'b0;
    br_cond = 1'b0;
    if (op6 == OP_SIGNED_ADD) begin
      is_add = 1'b1;
    end else if (op6 == OP_SIGNED_ADD_IMM) begin
      is_addi = 1'b1;
    end else if (op6 == OP_AND) begin
      is_and = 1'b1;
    end else if (op6 == OP_CLEAR_BITS) begin
      is_clear_bits_op = 1'b1;
    end else if (op6 == OP_CLEAR_BITS_IMM) begin
      is_clear_bits_imm_op = 1'b1;
    end else if (insn_i[7] == 1'b0) begin
      // bit 7 must be zero in the relative branch format
      is_br = 1'b1;
      case (op8)
        OP_JUMP_IF_CARRY: br_cond = c_f;
        OP_JUMP_IF_ZERO: br_cond = z_f;
        OP_JUMP_IF_NONNEG: br_cond = ~n_f;
        OP_JUMP_IF_POSITIVE: br_cond = ~n_f & ~z_f;
        OP_JUMP_IF_NO_CARRY: br_cond = ~c_f;
        default: is_br = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // arithmetic
  logic [31:0] addend, sum, logic_res, res;
  logic [32:0] sum_w;
  logic ovf, is_arith, known;
  always_comb begin
    addend = src_data_i;
    if (is_add && insn_i[8] == 1'b0 && insn_i[3:0] == STATE_WORD_CODE) begin
      addend = {31'h0000_0000, c_f};
    end
    if (is_addi) begin
      addend = imm_val_i;
      if (imm_sel_o == 5'h00) begin
        addend = {31'h0000_0000, c_f & (~z_f | dst_data_i[0])};
      end
    end
  end
  assign sum_w = {1'b0, dst_data_i} + {1'b0, addend};
  assign sum = sum_w[31:0];
  // signed overflow: equal operand signs, differing result sign
  assign ovf = (dst_data_i[31] == addend[31]) &&
               (sum[31] != dst_data_i[31]);
  always_comb begin
    logic_res = dst_data_i & src_data_i;
    if (is_clear_bits_op) begin
      logic_res = dst_data_i & ~src_data_i;
    end else if (is_clear_bits_imm_op) begin
      logic_res = dst_data_i & ~imm_val_i;
    end
  end
  assign is_arith = is_add | is_addi;
  assign res = is_arith ? sum : logic_res;
  assign known = is_arith | is_and | is_clear_bits_op | is_clear_bits_imm_op | is_br;

  // ==========================================================
  // commit qualifiers
  logic is_logic;
  logic taken;
  logic commit_arith;
  logic commit_logic;
  logic commit_jump;
  logic commit_write;
  logic sum_zero;
  logic logic_zero;

  assign is_logic = is_and | is_clear_bits_op | is_clear_bits_imm_op;
  assign taken = is_br & br_cond;
  assign commit_arith = insn_valid_i & is_arith;
  assign commit_logic = insn_valid_i & is_logic;
  assign commit_jump = insn_valid_i & taken;
  // only the destination is written; the source stays intact unless it is the same register
  assign commit_write = insn_valid_i & known & ~is_br;
  assign sum_zero = (sum == 32'h0000_0000);
  assign logic_zero = (logic_res == 32'h0000_0000);

  // ==========================================================
  // result write toward the register file
  albx_reg_wr_s wr_d;

  always_comb begin
    wr_d.we = commit_write;
    wr_d.sel = dst_sel_o;
    wr_d.data = res;
  end

  // a one-cycle write pulse; there is no forwarding to the next read
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_o <= '0;
    end else begin
      wr_o <= wr_d;
    end
  end

  // ==========================================================
  // flags: add sets z n v c, logic only z, jumps only m
  logic c_d;
  logic z_d;
  logic n_d;
  logic v_d;
  logic m_d;

  // an untaken jump or an unknown word leaves every flag alone
  always_comb begin
    c_d = c_q;
    z_d = z_q;
    n_d = n_q;
    v_d = v_q;
    m_d = m_q;
    if (commit_arith) begin
      c_d = sum_w[32];
      z_d = sum_zero;
      n_d = sum[31];
      v_d = ovf;
    end else if (commit_logic) begin
      z_d = logic_zero;
    end else if (commit_jump) begin
      m_d = 1'b0;
    end
  end

  // one register per flag, each with its own reset value
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      c_q <= STATE_WORD_RESET[FLAG_C];
    end else begin
      c_q <= c_d;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      z_q <= STATE_WORD_RESET[FLAG_Z];
    end else begin
      z_q <= z_d;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      n_q <= STATE_WORD_RESET[FLAG_N];
    end else begin
      n_q <= n_d;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      v_q <= STATE_WORD_RESET[FLAG_V];
    end else begin
      v_q <= v_d;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      m_q <= STATE_WORD_RESET[FLAG_M];
    end else begin
      m_q <= m_d;
    end
  end

  // bits without a flag read back their reset value
  always_comb begin
    state_word_o = STATE_WORD_RESET;
    state_word_o[FLAG_C] = c_q;
    state_word_o[FLAG_Z] = z_q;
    state_word_o[FLAG_N] = n_q;
    state_word_o[FLAG_V] = v_q;
    state_word_o[FLAG_M] = m_q;
  end

  // ==========================================================
  // program counter: next word, or next word plus the offset
  logic [31:0] pc_seq;
  logic [31:0] pc_d;

  assign pc_seq = pc_q + INSN_BYTES;
  always_comb begin
    pc_d = pc_seq;
    if (taken) begin
      pc_d = pc_seq + rel;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_q <= PC_RESET;
    end else if (insn_valid_i) begin
      pc_q <= pc_d;
    end
  end

  assign pc_o = pc_q;

  // ==========================================================
  // trap and illegal-word pulses
  // one pulse per overflowing add, on the edge its result commits
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      range_trap_o <= 1'b0;
    end else begin
      range_trap_o <= commit_arith & ovf;
    end
  end

  // an unknown word still advances pc but writes nothing
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      illegal_o <= 1'b0;
    end else begin
      illegal_o <= insn_valid_i & ~known;
    end
  end

  // ==========================================================
  // interrupt registers: range trap and taken jump events
  logic pc_jump_q;
  logic [1:0] irq_ev;
  logic [1:0] irq_clr;
  logic [1:0] irq_st_q;
  logic [1:0] irq_st_d;
  logic [1:0] irq_en_q;
  logic clr_hit;
  logic en_hit;
  logic [31:0] rdata_d;

  assign clr_hit = reg_wr_i && reg_addr_i == REG_IRQ_CLEAR;
  assign en_hit = reg_wr_i && reg_addr_i == REG_IRQ_ENABLE;
  assign irq_clr = clr_hit ? reg_wdata_i[1:0] : 2'h0;

  // a jump counts as an event in the cycle after it is taken
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pc_jump_q <= 1'b0;
    end else begin
      pc_jump_q <= commit_jump;
    end
  end

  assign irq_ev[IRQ_RANGE] = range_trap_o;
  assign irq_ev[IRQ_JUMP] = pc_jump_q;
  // a new event wins over a clear in the same cycle, so none is lost
  assign irq_st_d = (irq_st_q & ~irq_clr) | irq_ev;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_st_q <= 2'h0;
    end else begin
      irq_st_q <= irq_st_d;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_en_q <= IRQ_ENABLE_RESET;
    end else if (en_hit) begin
      irq_en_q <= reg_wdata_i[1:0];
    end
  end

  // status and enable read back; clear and unused offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd_i) begin
      if (reg_addr_i == REG_IRQ_STATUS) begin
        rdata_d = {30'h0000_0000, irq_st_q};
      end else if (reg_addr_i == REG_IRQ_ENABLE) begin
        rdata_d = {30'h0000_0000, irq_en_q};
      end
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= rdata_d;
    end
  end

  assign irq_o = |(irq_st_q & irq_en_q);
endmodule // albx_exec

// ---- tb/albx_rf_model.sv ----
// Purpose: register file on the far side of albx_exec
// Assumes: two banks of sixteen words, combinational reads
// Notes: the bench presets words through mem
`timescale 1ns/1ns
module albx_rf_model
  import albx_pkg::*;
(
  // design side
  input wire logic clk_i,
  input wire albx_reg_sel_s src_sel_i,
  input wire albx_reg_sel_s dst_sel_i,
  input wire albx_reg_wr_s wr_i,
  output logic [31:0] src_data_o,
  output logic [31:0] dst_data_o
);
  logic [31:0] mem [32];
  assign src_data_o = mem[src_sel_i];
  assign dst_data_o = mem[dst_sel_i];
  always @(posedge clk_i) begin
    if (wr_i.we) begin
      mem[wr_i.sel] <= wr_i.data;
    end
  end
endmodule // albx_rf_model

// ---- tb/albx_exec_checker.sv ----
// Purpose: port assertions for albx_exec
// Assumes: one clock domain
// Notes: bound to every albx_exec
`timescale 1ns/1ns
module albx_exec_checker
  import albx_pkg::*;
(
  // watched ports
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic insn_valid_i,
  input wire logic [15:0] insn_i,
  input wire albx_reg_sel_s src_sel_o,
  input wire albx_reg_sel_s dst_sel_o,
  input wire logic [4:0] imm_sel_o,
  input wire albx_reg_wr_s wr_o,
  input wire logic [31:0] pc_o,
  input wire logic [31:0] state_word_o,
  input wire logic range_trap_o
);
  logic [31:0] jump_tgt;
  logic [31:0] seq_pc;
  logic add_op;
  logic [7:0] op8;
  assign op8 = insn_i[15:8];
  assign seq_pc = pc_o + INSN_BYTES;
  assign jump_tgt = seq_pc + {{25{insn_i[0]}}, insn_i[6:1], 1'b0};
  assign add_op = insn_valid_i && (insn_i[15:10] == OP_SIGNED_ADD ||
    insn_i[15:10] == OP_SIGNED_ADD_IMM);
  // ==========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_src_sel: assert property (src_sel_o == {insn_i[8], insn_i[3:0]})
    else $error("source select wrong");
  a_dst_sel: assert property (dst_sel_o == {insn_i[9], insn_i[7:4]})
    else $error("destination select wrong");
  a_imm_sel: assert property (imm_sel_o == {insn_i[8], insn_i[3:0]})
    else $error("immediate selector wrong");
  a_trap_follows_v: assert property (add_op |=>
    range_trap_o == state_word_o[FLAG_V]) else $error("trap not with V");
  a_trap_cause: assert property (range_trap_o |-> $past(add_op))
    else $error("trap without add");
  a_and_zero: assert property (insn_valid_i && insn_i[15:10] == OP_AND
    |=> wr_o.we && state_word_o[FLAG_Z] == (wr_o.data == 32'h0))
    else $error("and zero flag wrong");
  a_jump_keeps_flags: assert property (insn_valid_i && op8[7:4] == 4'hF
    |=> !wr_o.we && $stable(state_word_o[3:0])) else $error("jump hit flags");
  a_carry_taken: assert property (insn_valid_i && op8 == OP_JUMP_IF_CARRY
    && state_word_o[FLAG_C] |=> pc_o == $past(jump_tgt)
    && !state_word_o[FLAG_M]) else $error("carry jump wrong");
  a_no_carry_seq: assert property (insn_valid_i && op8 == OP_JUMP_IF_NO_CARRY
    && state_word_o[FLAG_C] |=> pc_o == $past(seq_pc))
    else $error("untaken jump moved pc");
endmodule // albx_exec_checker
bind albx_exec albx_exec_checker i_albx_exec_checker (.clk_i, .resetn_i,
  .insn_valid_i, .insn_i, .src_sel_o, .dst_sel_o, .imm_sel_o, .wr_o, .pc_o,
  .state_word_o, .range_trap_o);

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for albx_exec
// Assumes: rows run in order, flags carry from row to row
// Notes: G3 is the destination in every writing row but the local bank one (L3); G2 the source unless a row reads the state word, an immediate or L2
`timescale 1ns/1ns
module testbench
  import albx_pkg::*;
;
  typedef struct packed {
    logic [15:0] i;
    logic [31:0] a, b, r;
    logic [3:0] f;
    logic t, w;
    logic [31:0] p;
  } albx_row_s;
  logic clk_i, resetn_i, insn_valid_i, reg_wr_i, reg_rd_i, range_trap_o;
  logic illegal_o, irq_o;
  logic [15:0] insn_i;
  logic [31:0] src_data_i, dst_data_i, imm_val_i, reg_wdata_i, reg_rdata_o;
  logic [31:0] pc_o, state_word_o, old_pc;
  logic [3:0] reg_addr_i;
  logic [4:0] imm_sel_o;
  albx_reg_sel_s src_sel_o, dst_sel_o;
  albx_reg_wr_s wr_o;
  int err_count, cmp_count, cyc;
  // ==========================================================
  // insn, dst, src or imm, result, VNZC, trap, write, pc step
  albx_row_s rows [18] = '{
    '{16'h2C32, 32'h1, 32'h2, 32'h3, 4'h0, 1'b0, 1'b1, 32'h2},
    '{16'h2C32, 32'h7FFFFFFF, 32'h1, 32'h80000000, 4'hC, 1'b1, 1'b1, 32'h2},
    '{16'h2C32, 32'hFFFFFFFF, 32'h1, 32'h0, 4'h3, 1'b0, 1'b1, 32'h2},
    '{16'hF40A, 32'h0, 32'h0, 32'h0, 4'h3, 1'b0, 1'b0, 32'hC},
    '{16'hF27F, 32'h0, 32'h0, 32'h0, 4'h3, 1'b0, 1'b0, 32'h0},
    '{16'hF541, 32'h0, 32'h0, 32'h0, 4'h3, 1'b0, 1'b0, 32'h2},
    '{16'hFB02, 32'h0, 32'h0, 32'h0, 4'h3, 1'b0, 1'b0, 32'h2},
    '{16'hF901, 32'h0, 32'h0, 32'h0, 4'h3, 1'b0, 1'b0, 32'hFFFFFF82},
    '{16'h5432, 32'hF0F00000, 32'h0F0F0000, 32'h0, 4'h3, 1'b0, 1'b1, 32'h2},
    '{16'h3432, 32'hFFFFFFFF, 32'hFF, 32'hFFFFFF00, 4'h1, 1'b0, 1'b1, 32'h2},
    '{16'h7433, 32'hFF, 32'hF, 32'hF0, 4'h1, 1'b0, 1'b1, 32'h2},
    '{16'h6C30, 32'h4, 32'h0, 32'h5, 4'h0, 1'b0, 1'b1, 32'h2},
    '{16'h2C32, 32'hFFFFFFFF, 32'h1, 32'h0, 4'h3, 1'b0, 1'b1, 32'h2},
    '{16'h2C31, 32'h5, 32'h0, 32'h6, 4'h0, 1'b0, 1'b1, 32'h2},
    '{16'h2C32, 32'hFFFFFFFF, 32'h1, 32'h0, 4'h3, 1'b0, 1'b1, 32'h2},
    '{16'h6C30, 32'h2, 32'h0, 32'h2, 4'h0, 1'b0, 1'b1, 32'h2},
    '{16'hF402, 32'h0, 32'h0, 32'h0, 4'h0, 1'b0, 1'b0, 32'h2},
    '{16'hFB02, 32'h0, 32'h0, 32'h0, 4'h0, 1'b0, 1'b0, 32'h4}};
  albx_exec i_albx_exec (.clk_i, .resetn_i, .insn_valid_i, .insn_i,
    .src_sel_o, .dst_sel_o, .src_data_i, .dst_data_i, .wr_o, .imm_sel_o,
    .imm_val_i, .pc_o, .state_word_o, .range_trap_o, .illegal_o,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);
  albx_rf_model i_albx_rf_model (.clk_i, .src_sel_i(src_sel_o),
    .dst_sel_i(dst_sel_o), .wr_i(wr_o), .src_data_o(src_data_i),
    .dst_data_o(dst_data_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      err_count++;
    end
  endtask
  // idle edges first so the model's write never meets the preset
  task automatic run(input albx_row_s x);
    repeat (2) @(posedge clk_i);
    i_albx_rf_model.mem[2] <= x.b;
    i_albx_rf_model.mem[3] <= x.a;
    imm_val_i <= x.b;
    insn_i <= x.i;
    insn_valid_i <= 1'b1;
    old_pc = pc_o;
    @(posedge clk_i);
    insn_valid_i <= 1'b0;
    #1;
    chk(pc_o - old_pc, x.p);
    chk({28'h0, state_word_o[3:0]}, {28'h0, x.f});
    chk({31'h0, range_trap_o}, {31'h0, x.t});
    chk({31'h0, wr_o.we}, {31'h0, x.w});
    if (x.w) chk(wr_o.data, x.r);
    if (x.w) chk({27'h0, wr_o.sel}, {27'h0, x.i[9], x.i[7:4]});
  endtask
  task automatic reg_op(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    @(posedge clk_i);
    {reg_wr_i, reg_rd_i} <= 2'h0;
    #1;
    if (!w) chk(reg_rdata_o, d);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    {resetn_i, insn_valid_i, reg_wr_i, reg_rd_i} = 4'h0;
    {insn_i, imm_val_i, reg_addr_i, reg_wdata_i} = '0;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (rows[k]) run(rows[k]);
    // local bank: L3 = L3 + L2
    i_albx_rf_model.mem[18] <= 32'h10;
    i_albx_rf_model.mem[19] <= 32'h20;
    run('{16'h2F32, 32'h0, 32'h0, 32'h30, 4'h0, 1'b0, 1'b1, 32'h2});
    run('{16'h0000, 32'h0, 32'h0, 32'h0, 4'h0, 1'b0, 1'b0, 32'h2});
    chk({31'h0, illegal_o}, 32'h1);
    reg_op(1'b0, REG_IRQ_STATUS, 32'h3);
    chk({31'h0, irq_o}, 32'h0);
    reg_op(1'b1, REG_IRQ_ENABLE, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    reg_op(1'b1, REG_IRQ_CLEAR, 32'h3);
    chk({31'h0, irq_o}, 32'h0);
    reg_op(1'b0, REG_IRQ_STATUS, 32'h0);
    reg_op(1'b0, 4'hC, 32'h0);
    reg_op(1'b0, REG_IRQ_ENABLE, 32'h1);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(pc_o, PC_RESET);
    chk(state_word_o, STATE_WORD_RESET);
    chk({31'h0, irq_o}, 32'h0);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    reg_op(1'b0, REG_IRQ_ENABLE, 32'h0);
    stop_test();
  end
endmodule // testbench
